// ### dac_sink.sv
// Behavioural DAC at the far side, turning codes into signed offsets
`timescale 1ns/10ps
`default_nettype none
module dac_sink (
  input wire logic clock, // Sample clock
  input wire logic [seq_pkg::SAMPLE_W-1:0] code, // Code from sequencer
  output logic signed [seq_pkg::SAMPLE_W:0] offset_code, // Signed level, zero at midscale
  output int taken // Codes consumed
);
  // ----------------------------------------------------------------
  // Conversion, one code per clock
  // ----------------------------------------------------------------
  // Midscale 2047 maps to zero; codes are unsigned 0..4095 only
  always @(posedge clock) begin
    offset_code <= $signed({1'b0, code}) - 13'sd2047;
    taken <= taken + 1;
  end
  initial taken = 0;
endmodule : dac_sink
`default_nettype wire

// ### segment_sequencer_playback.sv
// Segment sequencer: steps linked waveform segments out to the DAC
//
// Contract
// - Descriptors decide start, length, repeats, waits
// - Samples and descriptors live in separate memories
// - Replay each segment repeat_count extra times
// - Nonzero segment_trigger_wait stalls for trigger
// - First segment obeys first_segment_triggered only
// - Auto mode: one trigger, zero loops forever
// - Timed mode: periodic triggers, loop count each
// - External trigger starts loop count playback
// - One sample per clock, ascending time order
// - Leading level awaiting first trigger, trailing after
// - Single segment start chosen by first_segment_triggered
// - Code 2047 means zero volts out
// - Repeat count 1..65535, zero loops forever
// - Up to 60 segments, each fully described
`timescale 1ns/10ps
`default_nettype none
module segment_sequencer_playback (
  input wire logic clock,                                   // 100 MHz sample clock
  input wire logic sys_rst,                                 // Async reset, high
  input wire logic run_start,                               // Start pulse
  input wire logic run_stop,                                // Stop pulse
  input wire seq_pkg::trig_mode_t trig_mode,                // Trigger mode
  input wire logic first_segment_triggered,                 // Segment 0 waits
  input wire logic sequence_loop,                           // Wrap sequence
  input wire logic [seq_pkg::REP_W-1:0] loop_count,         // Passes per trigger
  input wire logic [seq_pkg::SEG_W-1:0] num_segments,       // Segments in use
  input wire logic [seq_pkg::SAMPLE_W-1:0] leading_level,   // Pre-trigger code
  input wire logic [seq_pkg::SAMPLE_W-1:0] trailing_level,  // Post-run code
  input wire logic [seq_pkg::TMR_W-1:0] timed_period,       // Cycles per tick
  input wire logic ext_trig_en,                             // Pin trigger enable
  input wire logic ext_trig_pin,                            // Async trigger pin
  input wire logic soft_trig,                               // Software trigger
  input wire logic sample_we,                               // Sample write
  input wire logic [seq_pkg::ADDR_W-1:0] sample_waddr,      // Sample address
  input wire logic [seq_pkg::SAMPLE_W-1:0] sample_wdata,    // Sample value
  input wire logic desc_we,                                 // Descriptor write
  input wire logic [seq_pkg::SEG_W-1:0] desc_widx,          // Descriptor index
  input wire seq_pkg::segment_descriptor_t desc_wdata,      // Descriptor value
  output logic [seq_pkg::SAMPLE_W-1:0] dac_sample_q,        // DAC code
  output logic playing_q,                                   // Samples streaming
  output logic waiting_q,                                   // Awaiting trigger
  output logic done_q,                                      // Sequence ended
  output logic [seq_pkg::SEG_W-1:0] segment_q               // Current segment
);

  // ----------------------------------------------------------------
  // Types and state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,   // Stopped
    ST_ARM,    // Awaiting first trigger
    ST_PLAY,   // Streaming samples
    ST_SEGW,   // Stalled between segments
    ST_TRAIL   // Finished, trailing level
  } seq_state_t;

  seq_state_t state_q;                       // Sequencer state
  logic [seq_pkg::LEN_W-1:0] offset_q;       // Sample within segment
  logic [seq_pkg::REP_W-1:0] rep_q;          // Extra plays done
  logic [seq_pkg::REP_W-1:0] pass_q;         // Sequence passes done
  logic [seq_pkg::TMR_W-1:0] tmr_q;          // Timed trigger counter
  logic auto_pend_q;                         // One-shot auto trigger
  logic ext_s1_q, ext_s2_q, ext_s3_q;        // Pin synchroniser and history

  seq_mem_if mif ();                         // Memory read paths

  // ----------------------------------------------------------------
  // Memories
  // ----------------------------------------------------------------
  // Samples and descriptors sit in their own stores and read in parallel
  seq_sample_mem u_samples (
    .clock(clock),
    .wr_en(sample_we),
    .wr_addr(sample_waddr),
    .wr_data(sample_wdata),
    .rd(mif.smem)
  );

  seq_cmd_mem u_commands (
    .clock(clock),
    .wr_en(desc_we),
    .wr_idx(desc_widx),
    .wr_desc(desc_wdata),
    .rd(mif.cmem)
  );

  // ----------------------------------------------------------------
  // Descriptor decode
  // ----------------------------------------------------------------
  seq_pkg::segment_descriptor_t desc;         // Current descriptor
  logic [seq_pkg::LEN_W-1:0] addr_sum;        // Start plus offset
  logic seg_end;                              // Last sample of a play
  logic reps_done;                            // No further replays
  logic last_seg;                             // Final segment of sequence
  logic pass_more;                            // Another pass wanted
  logic trig_any;                             // Any trigger source
  logic timed_tick;                           // Timed trigger pulse
  logic ext_rise;                             // Trigger pin rising edge
  logic rearm;                                // Trailing state may retrigger

  assign mif.seg_idx = segment_q;
  assign desc = mif.desc;
  assign addr_sum = {1'b0, desc.start} + offset_q;
  assign mif.sample_addr = addr_sum[seq_pkg::ADDR_W-1:0];
  // Length below one sample would underflow; host keeps lengths legal
  assign seg_end = (offset_q == desc.length - seq_pkg::LEN_ONE);
  // Zero repeat count never finishes: the segment loops on itself
  assign reps_done = (desc.repeat_count != seq_pkg::COUNT_FOREVER)
                     && (rep_q == desc.repeat_count);
  assign last_seg = (segment_q == num_segments - seq_pkg::SEG_ONE);
  // Zero loop count runs for ever; timed mode should never be given it
  assign pass_more = sequence_loop || (loop_count == seq_pkg::COUNT_FOREVER)
                     || (pass_q != loop_count - seq_pkg::REP_ONE);
  assign rearm = first_segment_triggered && (trig_mode != seq_pkg::TRIG_AUTO);

  // ----------------------------------------------------------------
  // Trigger sources
  // ----------------------------------------------------------------
  // Pin passes two flops; the second and third stages feed the edge detector
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= ext_trig_pin;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  assign ext_rise = ext_trig_en && ext_s2_q && !ext_s3_q;

  // Period counter free runs while timed mode is active
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tmr_q <= '0;
    end else if ((state_q == ST_IDLE) || (trig_mode != seq_pkg::TRIG_TIMED)) begin
      tmr_q <= '0;
    end else if (timed_tick) begin
      tmr_q <= '0;
    end else begin
      tmr_q <= tmr_q + seq_pkg::TMR_ONE;
    end
  end

  // Period of zero wraps to the top threshold: a tick every 2^32 cycles
  assign timed_tick = (trig_mode == seq_pkg::TRIG_TIMED) && (state_q != ST_IDLE)
                      && (tmr_q >= timed_period - seq_pkg::TMR_ONE);

  // Auto mode owes exactly one trigger per start
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      auto_pend_q <= 1'b0;
    end else if (run_stop) begin
      auto_pend_q <= 1'b0;
    end else if (run_start) begin
      auto_pend_q <= (trig_mode == seq_pkg::TRIG_AUTO);
    end else if (state_q != ST_IDLE) begin
      // Spent once running, so later segment stalls still wait
      auto_pend_q <= 1'b0;
    end
  end

  assign trig_any = soft_trig || ext_rise || timed_tick || auto_pend_q;

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  logic play_adv;                              // Segment finished, no stall
  logic wait_adv;                              // Stall released by trigger
  logic do_adv;                                // Move to next segment
  logic restart;                               // Begin at segment zero

  assign play_adv = (state_q == ST_PLAY) && seg_end && reps_done
                    && !desc.segment_trigger_wait;
  assign wait_adv = (state_q == ST_SEGW) && trig_any;
  assign do_adv = play_adv || wait_adv;
  // Triggers count only in arm, segment wait or re-armed trailing; elsewhere they vanish
  assign restart = ((state_q == ST_ARM) && trig_any)
                   || ((state_q == ST_TRAIL) && rearm && trig_any);

  // Main state walk; stop wins over everything
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
    end else if (run_stop) begin
      state_q <= ST_IDLE;
    end else if (run_start) begin
      // Self-started first segment skips the arm wait
      state_q <= first_segment_triggered ? ST_ARM : ST_PLAY;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          state_q <= ST_IDLE;
        end
        ST_ARM, ST_TRAIL: begin
          if (restart) begin
            state_q <= ST_PLAY;
          end
        end
        ST_PLAY: begin
          if (seg_end && reps_done && desc.segment_trigger_wait) begin
            state_q <= ST_SEGW;
          end else if (play_adv && last_seg && !pass_more) begin
            state_q <= ST_TRAIL;
          end
        end
        ST_SEGW: begin
          if (wait_adv) begin
            state_q <= (last_seg && !pass_more) ? ST_TRAIL : ST_PLAY;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sample and repeat counters
  // ----------------------------------------------------------------
  // Offset walks one sample a clock, rewinding at each play's end
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      offset_q <= '0;
    end else if ((state_q != ST_PLAY) || run_start || seg_end) begin
      offset_q <= '0;
    end else begin
      offset_q <= offset_q + seq_pkg::LEN_ONE;
    end
  end

  // Extra plays of the current segment
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rep_q <= '0;
    end else if (run_start || restart || do_adv) begin
      rep_q <= '0;
    end else if ((state_q == ST_PLAY) && seg_end && !reps_done) begin
      rep_q <= rep_q + seq_pkg::REP_ONE;
    end
  end

  // Segment index: ascend, wrap from last to zero only on a new pass
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      segment_q <= seq_pkg::SEG_FIRST;
    end else if (run_start || restart) begin
      segment_q <= seq_pkg::SEG_FIRST;
    end else if (do_adv) begin
      if (!last_seg) begin
        segment_q <= segment_q + seq_pkg::SEG_ONE;
      end else if (pass_more) begin
        segment_q <= seq_pkg::SEG_FIRST;
      end
    end
  end

  // Completed passes of the whole sequence for this trigger
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pass_q <= '0;
    end else if (run_start || restart) begin
      pass_q <= '0;
    end else if (do_adv && last_seg && pass_more) begin
      pass_q <= pass_q + seq_pkg::REP_ONE;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // DAC code; midscale at reset keeps the analog output at zero volts
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      dac_sample_q <= seq_pkg::DAC_MIDSCALE;
    end else begin
      unique case (state_q)
        ST_IDLE, ST_ARM: begin
          dac_sample_q <= leading_level;
        end
        ST_PLAY: begin
          dac_sample_q <= mif.sample_data;
        end
        ST_SEGW: begin
          // Hold the last sample so a stall adds no step
          dac_sample_q <= dac_sample_q;
        end
        ST_TRAIL: begin
          dac_sample_q <= trailing_level;
        end
      endcase
    end
  end

  // Status flags, one cycle behind the state like the DAC code
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      playing_q <= 1'b0;
      waiting_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      playing_q <= (state_q == ST_PLAY);
      waiting_q <= (state_q == ST_ARM) || (state_q == ST_SEGW);
      done_q <= (state_q == ST_TRAIL);
    end
  end

endmodule : segment_sequencer_playback
`default_nettype wire

// ### seq_cmd_mem.sv
// Segment descriptor table, kept apart from sample storage
`timescale 1ns/10ps
`default_nettype none
module seq_cmd_mem (
  input wire logic clock,                                 // Sample clock
  input wire logic wr_en,                                 // Host write strobe
  input wire logic [seq_pkg::SEG_W-1:0] wr_idx,           // Descriptor index
  input wire seq_pkg::segment_descriptor_t wr_desc,       // Descriptor value
  seq_mem_if.cmem rd                                      // Sequencer read side
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  seq_pkg::segment_descriptor_t tbl_q [seq_pkg::MAX_SEGMENTS];  // Descriptors

  // Host load; indexes past the table are dropped
  always_ff @(posedge clock) begin
    if (wr_en && (int'(wr_idx) < seq_pkg::MAX_SEGMENTS)) begin
      tbl_q[wr_idx] <= wr_desc;
    end
  end

  // Out of range index reads an all-zero descriptor
  assign rd.desc = (int'(rd.seg_idx) < seq_pkg::MAX_SEGMENTS) ? tbl_q[rd.seg_idx] : '0;

endmodule : seq_cmd_mem
`default_nettype wire

// ### seq_mem_if.sv
// Read paths between the sequencer and its two memories
`timescale 1ns/10ps
`default_nettype none
interface seq_mem_if;
  logic [seq_pkg::ADDR_W-1:0] sample_addr;       // Sample read address
  logic [seq_pkg::SAMPLE_W-1:0] sample_data;     // Sample read data
  logic [seq_pkg::SEG_W-1:0] seg_idx;            // Descriptor read index
  seq_pkg::segment_descriptor_t desc;            // Descriptor read data

  modport seq (output sample_addr, seg_idx, input sample_data, desc);
  modport smem (input sample_addr, output sample_data);
  modport cmem (input seg_idx, output desc);
endinterface : seq_mem_if
`default_nettype wire

// ### seq_pkg.sv
// Shared constants and types for the segment sequencer
package seq_pkg;

  // ----------------------------------------------------------------
  // Widths and depths
  // ----------------------------------------------------------------
  localparam int SAMPLE_W = 12;        // DAC code width
  localparam int ADDR_W = 10;          // Sample memory address width
  localparam int SAMPLE_DEPTH = 1024;  // Sample memory words
  localparam int LEN_W = ADDR_W + 1;   // Segment length, may equal depth
  localparam int MAX_SEGMENTS = 60;    // Linked segment table size
  localparam int SEG_W = 6;            // Segment index width
  localparam int REP_W = 16;           // Repeat and loop counter width
  localparam int TMR_W = 32;           // Timed trigger period width

  // ----------------------------------------------------------------
  // Fixed values
  // ----------------------------------------------------------------
  localparam logic [SAMPLE_W-1:0] DAC_MIDSCALE = 12'h7FF;  // Zero volts out
  localparam logic [REP_W-1:0] COUNT_FOREVER = 16'h0000;   // Zero loops forever
  localparam logic [REP_W-1:0] REP_ONE = 16'h0001;
  localparam logic [LEN_W-1:0] LEN_ONE = 11'h001;
  localparam logic [SEG_W-1:0] SEG_ONE = 6'h01;
  localparam logic [SEG_W-1:0] SEG_FIRST = 6'h00;
  localparam logic [TMR_W-1:0] TMR_ONE = 32'h0000_0001;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TRIG_AUTO,      // One trigger on start
    TRIG_TIMED,     // Periodic internal trigger
    TRIG_EXTERNAL   // Trigger pin events
  } trig_mode_t;

  typedef struct packed {
    logic [ADDR_W-1:0] start;          // First sample address
    logic [LEN_W-1:0] length;          // Samples in segment
    logic [REP_W-1:0] repeat_count;    // Extra plays, zero is endless
    logic segment_trigger_wait;        // Stall for trigger before next
  } segment_descriptor_t;

endpackage : seq_pkg

// ### seq_play_asserts.sv
// Concurrent checks on the sequencer's top-level ports
`timescale 1ns/10ps
`default_nettype none
module seq_play_asserts (
  input wire logic clock, // Sample clock
  input wire logic sys_rst, // Async reset, high
  input wire logic run_start, // Start pulse
  input wire logic run_stop, // Stop pulse
  input wire seq_pkg::trig_mode_t trig_mode, // Trigger mode
  input wire logic [seq_pkg::SEG_W-1:0] num_segments, // Segments in use
  input wire logic [seq_pkg::SAMPLE_W-1:0] leading_level, // Pre-trigger code
  input wire logic [seq_pkg::SAMPLE_W-1:0] trailing_level, // Post-run code
  input wire logic [seq_pkg::SAMPLE_W-1:0] dac_sample_q, // DAC code
  input wire logic playing_q, // Streaming flag
  input wire logic waiting_q, // Waiting flag
  input wire logic done_q, // Ended flag
  input wire logic [seq_pkg::SEG_W-1:0] segment_q // Current segment
);
  // ----------------------------------------------------------------
  // Clock and reset
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Reset leaves the output at midscale, which is zero volts
  AST_RST_MID: assert property ($fell(sys_rst) |-> dac_sample_q == seq_pkg::DAC_MIDSCALE)
    else $error("output not midscale after reset");
  // At most one activity flag at a time
  AST_ONE_STATE: assert property ($onehot0({playing_q, waiting_q, done_q}))
    else $error("several activity flags at once");
  // A start puts the sequencer into play or arm within two edges
  AST_START: assert property (run_start && !run_stop |-> ##2 (playing_q || waiting_q))
    else $error("start did not take effect");
  // A stop returns to idle on the leading level
  AST_STOP_IDLE: assert property (run_stop |-> ##2 (!playing_q && !waiting_q && !done_q
    && dac_sample_q == leading_level))
    else $error("stop did not return to idle level");
  // Entering the end state shows the trailing level
  AST_TRAIL_LEVEL: assert property ($rose(done_q) |-> dac_sample_q == trailing_level)
    else $error("end state not on trailing level");
  // While waiting for a trigger the output is frozen
  AST_WAIT_HOLD: assert property (waiting_q && $past(waiting_q) |-> $stable(dac_sample_q))
    else $error("output moved while waiting");
  // Segment index only steps up by one or wraps to zero
  AST_SEG_ORDER: assert property (segment_q != $past(segment_q) |->
    (segment_q == $past(segment_q) + seq_pkg::SEG_ONE || segment_q == seq_pkg::SEG_FIRST))
    else $error("segment index jumped");
  // Playback never runs past the segments in use
  AST_SEG_RANGE: assert property (playing_q |-> segment_q < num_segments)
    else $error("segment index out of range");
  // Auto mode has no re-arm from the end state
  AST_AUTO_TRAIL: assert property (done_q && trig_mode == seq_pkg::TRIG_AUTO && !run_start
    && !run_stop && !$past(run_start) && !$past(run_stop) |=> done_q)
    else $error("end state left without start or stop");

  // ----------------------------------------------------------------
  // Coverage of the main scenarios
  // ----------------------------------------------------------------
  COV_DONE: cover property ($rose(done_q));
  COV_WAIT: cover property ($rose(waiting_q));
  COV_WRAP: cover property (segment_q == seq_pkg::SEG_FIRST && $past(segment_q) != seq_pkg::SEG_FIRST);
endmodule : seq_play_asserts
`default_nettype wire

// ### seq_sample_mem.sv
// Waveform sample storage, host written, sequencer read
`timescale 1ns/10ps
`default_nettype none
module seq_sample_mem (
  input wire logic clock,                                 // Sample clock
  input wire logic wr_en,                                 // Host write strobe
  input wire logic [seq_pkg::ADDR_W-1:0] wr_addr,         // Host write address
  input wire logic [seq_pkg::SAMPLE_W-1:0] wr_data,       // Host write sample
  seq_mem_if.smem rd                                      // Sequencer read side
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [seq_pkg::SAMPLE_W-1:0] mem_q [seq_pkg::SAMPLE_DEPTH];  // Sample words

  // Host load; no reset, contents are defined by software before run
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  // Combinational read so the sequencer can register one sample per clock
  assign rd.sample_data = mem_q[rd.sample_addr];

endmodule : seq_sample_mem
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the segment sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  // ----------------------------------------------------------------
  // Stimulus and observation signals
  // ----------------------------------------------------------------
  logic clock = 1'b0, sys_rst = 1'b1, run_start = 1'b0, run_stop = 1'b0;
  seq_pkg::trig_mode_t trig_mode = seq_pkg::TRIG_AUTO; // Trigger source
  logic fst = 1'b0, seq_loop = 1'b0, ext_en = 1'b0, ext_pin = 1'b0, soft_trig = 1'b0;
  logic [15:0] loop_count = 16'h0001; // Passes per trigger
  logic [5:0] num_seg = 6'h02; // Segments in use
  logic [11:0] lead = 12'h0A5, trail = 12'h0E1; // Distinct from every sample
  logic [31:0] period = 32'h0000_0028; // Timed tick spacing
  logic s_we = 1'b0, d_we = 1'b0;
  logic [9:0] s_addr = 10'h000;
  logic [11:0] s_data = 12'h000;
  logic [5:0] d_idx = 6'h00;
  seq_pkg::segment_descriptor_t d_data = '0;
  logic [11:0] dac_sample_q, exp_q[$];
  logic playing_q, waiting_q, done_q;
  logic [5:0] segment_q;
  logic signed [12:0] offset_code;
  int err_count = 0, compares = 0;

  always #5 clock = ~clock; // 100 MHz

  segment_sequencer_playback u_dut (.clock(clock), .sys_rst(sys_rst), .run_start(run_start),
    .run_stop(run_stop), .trig_mode(trig_mode), .first_segment_triggered(fst),
    .sequence_loop(seq_loop), .loop_count(loop_count), .num_segments(num_seg),
    .leading_level(lead), .trailing_level(trail), .timed_period(period),
    .ext_trig_en(ext_en), .ext_trig_pin(ext_pin), .soft_trig(soft_trig),
    .sample_we(s_we), .sample_waddr(s_addr), .sample_wdata(s_data), .desc_we(d_we),
    .desc_widx(d_idx), .desc_wdata(d_data), .dac_sample_q(dac_sample_q),
    .playing_q(playing_q), .waiting_q(waiting_q), .done_q(done_q), .segment_q(segment_q));
  dac_sink u_dac (.clock(clock), .code(dac_sample_q), .offset_code(offset_code), .taken());

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Compare and count; an unknown matches only an identical unknown
  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // One-cycle pulse launched on a falling edge
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clock);
    s = 1'b0;
  endtask : pulse
  // Descriptor write; every segment is 64 samples long
  task automatic wr_desc(input logic [5:0] idx, input logic [9:0] st, input logic [15:0] rep,
                         input logic wt);
    @(negedge clock);
    d_we = 1'b1;
    d_idx = idx;
    d_data = '{start: st, length: 11'h040, repeat_count: rep, segment_trigger_wait: wt};
    @(negedge clock);
    d_we = 1'b0;
  endtask : wr_desc
  // Queue the codes of one segment played a number of times
  task automatic add_seg(input int base, input int plays);
    for (int p = 0; p < plays; p++) begin
      for (int k = 0; k < 64; k++) exp_q.push_back(12'h100 + 12'(base + k));
    end
  endtask : add_seg
  // Find first queued code, then demand the rest
  task automatic play_check();
    int i;
    i = 0;
    while (dac_sample_q !== exp_q[0] && i < 300) begin
      @(negedge clock);
      i++;
    end
    if (i == 300) begin
      check(dac_sample_q, exp_q[0]);
      results();
    end
    foreach (exp_q[j]) begin
      check(dac_sample_q, exp_q[j]);
      @(negedge clock);
    end
    exp_q.delete();
  endtask : play_check
  // Verdict and end of run
  task automatic results();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(negedge clock);
    check(dac_sample_q, 12'h7FF);
    check(offset_code[11:0], 12'h000);
    sys_rst = 1'b0;
    // Sample load
    for (int a = 0; a < 256; a++) begin
      s_we = 1'b1;
      s_addr = 10'(a);
      s_data = 12'h100 + 12'(a);
      @(negedge clock);
    end
    s_we = 1'b0;
    // Auto, one pass, then trailing
    wr_desc(6'h00, 10'h000, 16'h0001, 1'b0);
    wr_desc(6'h01, 10'h080, 16'h0002, 1'b0);
    pulse(run_start);
    add_seg(0, 2);
    add_seg(128, 3);
    play_check();
    repeat (3) @(negedge clock);
    check({11'h000, done_q}, 12'h001);
    pulse(soft_trig);
    repeat (5) @(negedge clock);
    check(dac_sample_q, trail);
    check({6'h00, segment_q}, 12'h001);
    pulse(run_stop);
    $display("test auto once done");
    // Auto, endless passes wrap
    loop_count = 16'h0000;
    fst = 1'b1;
    pulse(run_start);
    add_seg(0, 2);
    add_seg(128, 3);
    add_seg(0, 2);
    play_check();
    pulse(run_stop);
    $display("test auto endless done");
    // External trigger, segment wait
    loop_count = 16'h0001;
    trig_mode = seq_pkg::TRIG_EXTERNAL;
    ext_en = 1'b1;
    wr_desc(6'h00, 10'h000, 16'h0001, 1'b1);
    pulse(run_start);
    repeat (10) @(negedge clock);
    check({11'h000, waiting_q}, 12'h001);
    check(dac_sample_q, lead);
    ext_pin = 1'b1;
    repeat (4) @(negedge clock);
    ext_pin = 1'b0;
    add_seg(0, 2);
    play_check();
    repeat (3) @(negedge clock);
    check({11'h000, waiting_q}, 12'h001);
    check(dac_sample_q, 12'h13F);
    pulse(soft_trig);
    add_seg(128, 3);
    play_check();
    repeat (3) @(negedge clock);
    check(dac_sample_q, trail);
    ext_pin = 1'b1;
    repeat (4) @(negedge clock);
    ext_pin = 1'b0;
    add_seg(0, 1);
    play_check();
    pulse(run_stop);
    $display("test external done");
    // Timed ticks restart
    trig_mode = seq_pkg::TRIG_TIMED;
    wr_desc(6'h00, 10'h000, 16'h0001, 1'b0);
    pulse(run_start);
    add_seg(0, 2);
    add_seg(128, 3);
    play_check();
    add_seg(0, 1);
    play_check();
    pulse(run_stop);
    $display("test timed done");
    repeat (3) @(negedge clock);
    results();
  end

  // Cut a hang short
  initial begin
    repeat (60000) @(posedge clock);
    err_count++;
    results();
  end
endmodule : tb_top

bind segment_sequencer_playback seq_play_asserts u_asserts (.clock, .sys_rst, .run_start,
  .run_stop, .trig_mode, .num_segments, .leading_level, .trailing_level, .dac_sample_q,
  .playing_q, .waiting_q, .done_q, .segment_q);
`default_nettype wire
